// ---- src/pdm_pkg.sv ----
// constants shared by the power-down mode controller
package pdm_pkg;

    // ****************************************************
    // register byte offsets on the avalon slave
    // ****************************************************
    localparam logic [4:0] OFS_STANDBY_CTRL = 5'h00;
    localparam logic [4:0] OFS_SYSTEM_CTRL  = 5'h04;
    localparam logic [4:0] OFS_IRQ_CTRL     = 5'h08;
    localparam logic [4:0] OFS_WDT_CTRL     = 5'h0c;
    localparam logic [4:0] OFS_WDT_RST_CTRL = 5'h10;
    localparam logic [4:0] OFS_WDT_COUNTER  = 5'h14;
    localparam logic [4:0] OFS_MODE_STATUS  = 5'h18;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int BIT_STANDBY_SELECT = 7;
    localparam int BIT_PORT_FLOAT     = 6;
    localparam int BIT_RAM_ON         = 0;
    localparam int BIT_WAKE_EDGE      = 0;
    localparam int BIT_WDT_OVERFLOW   = 7;
    localparam int BIT_WDT_MODE       = 6;
    localparam int BIT_WDT_RUN        = 5;
    localparam int WDT_CKS_MSB        = 2;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] RST_STANDBY_CTRL = 8'h1f;
    localparam logic [7:0] RST_SYSTEM_CTRL  = 8'h01;
    localparam logic [7:0] RST_IRQ_CTRL     = 8'h00;
    localparam logic [7:0] RST_WDT_CTRL     = 8'h18;
    localparam logic [7:0] RST_WDT_RST_CTRL = 8'h00;
    localparam logic [7:0] RST_WDT_COUNTER  = 8'h00;
    // bits of the control registers that never change
    localparam logic [7:0] FIX_STANDBY_CTRL = 8'h1f;
    localparam logic [7:0] FIX_WDT_CTRL     = 8'h18;

    // ****************************************************
    // timing counts
    // ****************************************************
    localparam int SYNC_STAGES = 3;
    localparam int WDT_PRESCALE_W = 16;

    // ****************************************************
    // operating modes
    // ****************************************************
    typedef enum logic [2:0] {
        PDM_RUN        = 3'b000,
        PDM_SLEEP      = 3'b001,
        PDM_SW_STANDBY = 3'b010,
        PDM_WAKE_OSC   = 3'b011,
        PDM_HW_STANDBY = 3'b100,
        PDM_POR_HOLD   = 3'b101
    } pdm_mode_e;

endpackage : pdm_pkg

// ---- src/pdm_wdt_if.sv ----
// link between the mode controller and its watchdog
`timescale 1ns/1ns
interface pdm_wdt_if;
    logic       wr_ctrl;
    logic       wr_rst_ctrl;
    logic       wr_counter;
    logic [7:0] wdata;
    logic       standby_init;
    logic       wake_run;
    logic [7:0] ctrl;
    logic [7:0] rst_ctrl;
    logic [7:0] counter;
    logic       overflow;

    modport ctl (output wr_ctrl, wr_rst_ctrl, wr_counter, wdata, standby_init, wake_run,
                 input  ctrl, rst_ctrl, counter, overflow);
    modport wdt (input  wr_ctrl, wr_rst_ctrl, wr_counter, wdata, standby_init, wake_run,
                 output ctrl, rst_ctrl, counter, overflow);
endinterface : pdm_wdt_if

// ---- src/pdm_wdt.sv ----
// watchdog that times oscillator settling on wake from software standby
`timescale 1ns/1ns
module pdm_wdt (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // control side
    pdm_wdt_if.wdt     wif
);
    logic [pdm_pkg::WDT_PRESCALE_W-1:0] presc_ff;
    logic [7:0]                         ctrl_ff;
    logic [7:0]                         rst_ctrl_ff;
    logic [7:0]                         counter_ff;
    logic                               overflow_ff;
    logic [pdm_pkg::WDT_PRESCALE_W-1:0] mask;
    logic                               counting;
    logic                               tick;
    logic                               wrap;

    // ****************************************************
    // prescaler tap chosen by the clock select field
    // ****************************************************
    always_comb begin
        mask = '0;
        for (int i = 0; i < pdm_pkg::WDT_PRESCALE_W; i++) begin
            if (i < 32'(ctrl_ff[pdm_pkg::WDT_CKS_MSB:0]) * 2 + 1) begin
                mask[i] = 1'b1;
            end
        end
    end

    assign counting = ctrl_ff[pdm_pkg::BIT_WDT_RUN] | wif.wake_run;
    assign tick     = counting && ((presc_ff & mask) == mask);
    assign wrap     = tick && (counter_ff == 8'hff);

    always_ff @(posedge clk) begin
        if (rst || wif.standby_init || !counting) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= presc_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || wif.standby_init) begin
            counter_ff <= pdm_pkg::RST_WDT_COUNTER;
        end else if (tick) begin
            counter_ff <= counter_ff + 8'h01;
        end else if (wif.wr_counter) begin
            counter_ff <= wif.wdata;
        end
    end

    // standby entry clears overflow, mode and run but keeps clock select
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= pdm_pkg::RST_WDT_CTRL;
        end else if (wif.standby_init) begin
            ctrl_ff <= {3'b000, ctrl_ff[4:0]} | pdm_pkg::FIX_WDT_CTRL;
        end else begin
            if (wif.wr_ctrl) begin
                ctrl_ff[pdm_pkg::BIT_WDT_MODE]        <= wif.wdata[pdm_pkg::BIT_WDT_MODE];
                ctrl_ff[pdm_pkg::BIT_WDT_RUN]         <= wif.wdata[pdm_pkg::BIT_WDT_RUN];
                ctrl_ff[pdm_pkg::WDT_CKS_MSB:0]       <= wif.wdata[pdm_pkg::WDT_CKS_MSB:0];
                // overflow flag is write-zero-to-clear
                if (!wif.wdata[pdm_pkg::BIT_WDT_OVERFLOW]) begin
                    ctrl_ff[pdm_pkg::BIT_WDT_OVERFLOW] <= 1'b0;
                end
            end
            // set beats a clear in the same cycle
            if (wrap && ctrl_ff[pdm_pkg::BIT_WDT_RUN]) begin
                ctrl_ff[pdm_pkg::BIT_WDT_OVERFLOW] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || wif.standby_init) begin
            rst_ctrl_ff <= pdm_pkg::RST_WDT_RST_CTRL;
        end else if (wif.wr_rst_ctrl) begin
            rst_ctrl_ff <= wif.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_ff <= 1'b0;
        end else begin
            overflow_ff <= wrap && wif.wake_run;
        end
    end

    assign wif.ctrl     = ctrl_ff;
    assign wif.rst_ctrl = rst_ctrl_ff;
    assign wif.counter  = counter_ff;
    assign wif.overflow = overflow_ff;

endmodule : pdm_wdt

// ---- src/pdm_top.sv ----
// power-down mode controller: sleep, software standby and hardware standby
`timescale 1ns/1ns

// Behaviour
// - sleep with standby select enters standby
// - cpu contents kept in standby; ram kept only when the ram-on bit is clear
// - standby initializes dma, timers, serial, converter
// - watchdog clears flags, counter; keeps clock select
// - ports hold or float per float select
// - standby ends on wake edge or reset
// - wake edge restarts oscillator, watchdog only
// - watchdog overflow resumes chip, starts wake exception
// - reset pin low ends software standby
// - sleep without standby select halts cpu
// - peripherals keep running during sleep
// - only acceptable interrupts end sleep
// - dma address error ends sleep
// - reset pin low ends sleep
// - standby pin low forces hardware standby asynchronously
// - standby select refused while watchdog runs
// - float select: 0 hold, 1 float; resets 0
module pdm_top #(
    parameter int IRQ_LEVEL_W = 4
) (
    // clock and reset
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST,
    // avalon-mm slave
    input  wire logic [4:0]             AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // device pins
    input  wire logic                   HW_STANDBY_N,
    input  wire logic                   POWER_ON_RESET_N,
    input  wire logic                   NMI_PIN,
    // cpu and interrupt side
    input  wire logic                   SLEEP_EXEC,
    input  wire logic                   IRQ_REQ,
    input  wire logic                   IRQ_ENABLED,
    input  wire logic [IRQ_LEVEL_W-1:0] IRQ_LEVEL,
    input  wire logic [IRQ_LEVEL_W-1:0] SR_MASK,
    input  wire logic                   DMA_ADDR_ERR,
    // power control outputs
    output logic                        CPU_HALT,
    output logic                        CPU_CLK_EN,
    output logic                        PERIPH_CLK_EN,
    output logic                        WDT_CLK_EN,
    output logic                        OSC_EN,
    output logic                        PERIPH_INIT,
    output logic                        PORT_HIZ,
    output logic                        RAM_RETAIN,
    output logic                        CHIP_RESET,
    output logic                        HW_STANDBY,
    // exception requests
    output logic                        NMI_EXC,
    output logic                        IRQ_EXC,
    output logic                        DMA_ERR_EXC
);
    // refused at elaboration, before any logic is built
    if (IRQ_LEVEL_W < 1 || IRQ_LEVEL_W > 8) begin : g_width_check
        $error("IRQ_LEVEL_W must lie in 1..8");
    end

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic [pdm_pkg::SYNC_STAGES-1:0] hw_standby_n_sync_ff;
    logic [pdm_pkg::SYNC_STAGES-1:0] res_sync_ff;
    logic [pdm_pkg::SYNC_STAGES-1:0] wake_sync_ff;
    logic                            hw_standby_n_n_ff;
    logic                            res_n_ff;
    logic                            wake_seen_sync_ff;
    logic                            wake_seen_ff;

    always_ff @(posedge CLK_SYS) begin
        hw_standby_n_sync_ff <= {hw_standby_n_sync_ff[1:0], HW_STANDBY_N};
        res_sync_ff   <= {res_sync_ff[1:0], POWER_ON_RESET_N};
        wake_sync_ff  <= {wake_sync_ff[1:0], wake_seen_ff};
    end

    // a level counts once the last two stages agree
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hw_standby_n_n_ff        <= 1'b1;
            res_n_ff          <= 1'b1;
            wake_seen_sync_ff <= 1'b0;
        end else begin
            if (hw_standby_n_sync_ff[1] == hw_standby_n_sync_ff[2]) begin
                hw_standby_n_n_ff <= hw_standby_n_sync_ff[2];
            end
            if (res_sync_ff[1] == res_sync_ff[2]) begin
                res_n_ff <= res_sync_ff[2];
            end
            if (wake_sync_ff[1] == wake_sync_ff[2]) begin
                wake_seen_sync_ff <= wake_sync_ff[2];
            end
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    logic                 standby_select_bit_ff;
    logic                 port_float_select_ff;
    logic                 ram_on_ff;
    logic                 wake_edge_select_ff;
    logic                 wait_ff;
    logic [31:0]          rdata_ff;
    logic                 req;
    logic                 wr_take;
    logic                 reg_init;
    pdm_pkg::pdm_mode_e   mode_ff;
    pdm_pkg::pdm_mode_e   nxt_mode;
    pdm_wdt_if            wif ();

    assign req      = AVS_READ | AVS_WRITE;
    assign wr_take  = AVS_WRITE && !wait_ff && AVS_BYTEENABLE[0];
    // the standby, system and interrupt control registers are initialized by reset, the reset pin and hardware standby; software standby entry leaves them alone
    assign reg_init = RST || !res_n_ff || mode_ff == pdm_pkg::PDM_HW_STANDBY;

    // one wait cycle, then the answer stands for one edge
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !(req && wait_ff);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (reg_init) begin
            standby_select_bit_ff <= pdm_pkg::RST_STANDBY_CTRL[pdm_pkg::BIT_STANDBY_SELECT];
            port_float_select_ff  <= pdm_pkg::RST_STANDBY_CTRL[pdm_pkg::BIT_PORT_FLOAT];
        end else if (wr_take && AVS_ADDRESS == pdm_pkg::OFS_STANDBY_CTRL) begin
            // both bits stay put while the watchdog runs
            if (!wif.ctrl[pdm_pkg::BIT_WDT_RUN]) begin
                standby_select_bit_ff <= AVS_WRITEDATA[pdm_pkg::BIT_STANDBY_SELECT];
                port_float_select_ff  <= AVS_WRITEDATA[pdm_pkg::BIT_PORT_FLOAT];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (reg_init) begin
            ram_on_ff <= pdm_pkg::RST_SYSTEM_CTRL[pdm_pkg::BIT_RAM_ON];
        end else if (wr_take && AVS_ADDRESS == pdm_pkg::OFS_SYSTEM_CTRL) begin
            ram_on_ff <= AVS_WRITEDATA[pdm_pkg::BIT_RAM_ON];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (reg_init) begin
            wake_edge_select_ff <= pdm_pkg::RST_IRQ_CTRL[pdm_pkg::BIT_WAKE_EDGE];
        end else if (wr_take && AVS_ADDRESS == pdm_pkg::OFS_IRQ_CTRL) begin
            wake_edge_select_ff <= AVS_WRITEDATA[pdm_pkg::BIT_WAKE_EDGE];
        end
    end

    assign wif.wdata       = AVS_WRITEDATA[7:0];
    assign wif.wr_ctrl     = wr_take && AVS_ADDRESS == pdm_pkg::OFS_WDT_CTRL;
    assign wif.wr_rst_ctrl = wr_take && AVS_ADDRESS == pdm_pkg::OFS_WDT_RST_CTRL;
    assign wif.wr_counter  = wr_take && AVS_ADDRESS == pdm_pkg::OFS_WDT_COUNTER;

    // unmapped offsets read as zero, writes to them are dropped
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (AVS_READ && wait_ff) begin
            case (AVS_ADDRESS)
                pdm_pkg::OFS_STANDBY_CTRL: begin
                    rdata_ff <= {24'h00_0000, standby_select_bit_ff, port_float_select_ff,
                                 pdm_pkg::FIX_STANDBY_CTRL[5:0]};
                end
                pdm_pkg::OFS_SYSTEM_CTRL:  rdata_ff <= {31'h0000_0000, ram_on_ff};
                pdm_pkg::OFS_IRQ_CTRL:     rdata_ff <= {31'h0000_0000, wake_edge_select_ff};
                pdm_pkg::OFS_WDT_CTRL:     rdata_ff <= {24'h00_0000, wif.ctrl};
                pdm_pkg::OFS_WDT_RST_CTRL: rdata_ff <= {24'h00_0000, wif.rst_ctrl};
                pdm_pkg::OFS_WDT_COUNTER:  rdata_ff <= {24'h00_0000, wif.counter};
                pdm_pkg::OFS_MODE_STATUS:  rdata_ff <= {29'h0000_0000, mode_ff};
                default:                   rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // clockless wake edge catcher
    // ****************************************************
    // the selected edge is turned into a rising one; the select only
    // changes while the catcher is held clear, so its glitch is harmless
    logic nmi_edge;
    logic wake_clr_ff;

    assign nmi_edge = NMI_PIN ^ ~wake_edge_select_ff;

    always_ff @(posedge nmi_edge or posedge wake_clr_ff) begin
        if (wake_clr_ff) begin
            wake_seen_ff <= 1'b0;
        end else begin
            wake_seen_ff <= 1'b1;
        end
    end

    // armed only while the oscillator is stopped in software standby
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wake_clr_ff <= 1'b1;
        end else begin
            wake_clr_ff <= nxt_mode != pdm_pkg::PDM_SW_STANDBY;
        end
    end

    // ****************************************************
    // mode sequencer
    // ****************************************************
    logic irq_accept;

    assign irq_accept = IRQ_REQ && IRQ_ENABLED && (IRQ_LEVEL > SR_MASK);

    always_comb begin
        nxt_mode = mode_ff;
        if (!hw_standby_n_n_ff) begin
            nxt_mode = pdm_pkg::PDM_HW_STANDBY;
        end else if (!res_n_ff) begin
            nxt_mode = pdm_pkg::PDM_POR_HOLD;
        end else begin
            case (mode_ff)
                pdm_pkg::PDM_RUN: begin
                    if (SLEEP_EXEC) begin
                        nxt_mode = standby_select_bit_ff ? pdm_pkg::PDM_SW_STANDBY
                                                         : pdm_pkg::PDM_SLEEP;
                    end
                end
                pdm_pkg::PDM_SLEEP: begin
                    if (irq_accept || DMA_ADDR_ERR) begin
                        nxt_mode = pdm_pkg::PDM_RUN;
                    end
                end
                pdm_pkg::PDM_SW_STANDBY: begin
                    if (wake_seen_sync_ff) begin
                        nxt_mode = pdm_pkg::PDM_WAKE_OSC;
                    end
                end
                pdm_pkg::PDM_WAKE_OSC: begin
                    if (wif.overflow) begin
                        nxt_mode = pdm_pkg::PDM_RUN;
                    end
                end
                pdm_pkg::PDM_HW_STANDBY: nxt_mode = pdm_pkg::PDM_POR_HOLD;
                pdm_pkg::PDM_POR_HOLD:   nxt_mode = pdm_pkg::PDM_RUN;
                default:                 nxt_mode = pdm_pkg::PDM_POR_HOLD;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mode_ff <= pdm_pkg::PDM_POR_HOLD;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // the standby pin wins at once, clock or no clock
    always_ff @(posedge CLK_SYS or negedge HW_STANDBY_N) begin
        if (!HW_STANDBY_N) begin
            HW_STANDBY <= 1'b1;
        end else if (RST) begin
            HW_STANDBY <= 1'b0;
        end else begin
            HW_STANDBY <= nxt_mode == pdm_pkg::PDM_HW_STANDBY;
        end
    end

    assign wif.standby_init = mode_ff == pdm_pkg::PDM_RUN && nxt_mode == pdm_pkg::PDM_SW_STANDBY;
    assign wif.wake_run     = mode_ff == pdm_pkg::PDM_WAKE_OSC;

    pdm_wdt u_wdt (
        .clk (CLK_SYS),
        .rst (RST || !res_n_ff || mode_ff == pdm_pkg::PDM_HW_STANDBY),
        .wif (wif)
    );

    // ****************************************************
    // registered outputs
    // ****************************************************
    logic in_sw_standby;

    assign in_sw_standby = nxt_mode == pdm_pkg::PDM_SW_STANDBY
                        || nxt_mode == pdm_pkg::PDM_WAKE_OSC;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CPU_HALT      <= 1'b1;
            CPU_CLK_EN    <= 1'b0;
            PERIPH_CLK_EN <= 1'b0;
            WDT_CLK_EN    <= 1'b0;
            OSC_EN        <= 1'b1;
            PORT_HIZ      <= 1'b0;
            RAM_RETAIN    <= 1'b0;
            CHIP_RESET    <= 1'b1;
        end else begin
            // cpu registers are frozen, not cleared, while halted
            CPU_HALT      <= nxt_mode != pdm_pkg::PDM_RUN;
            CPU_CLK_EN    <= nxt_mode == pdm_pkg::PDM_RUN;
            PERIPH_CLK_EN <= nxt_mode == pdm_pkg::PDM_RUN
                          || nxt_mode == pdm_pkg::PDM_SLEEP;
            WDT_CLK_EN    <= nxt_mode == pdm_pkg::PDM_RUN
                          || nxt_mode == pdm_pkg::PDM_SLEEP
                          || nxt_mode == pdm_pkg::PDM_WAKE_OSC;
            OSC_EN        <= nxt_mode != pdm_pkg::PDM_SW_STANDBY
                          && nxt_mode != pdm_pkg::PDM_HW_STANDBY;
            PORT_HIZ      <= in_sw_standby && port_float_select_ff;
            RAM_RETAIN    <= in_sw_standby && !ram_on_ff;
            CHIP_RESET    <= nxt_mode == pdm_pkg::PDM_POR_HOLD
                          || nxt_mode == pdm_pkg::PDM_HW_STANDBY;
        end
    end

    // one-cycle pulses
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PERIPH_INIT <= 1'b0;
            NMI_EXC     <= 1'b0;
            IRQ_EXC     <= 1'b0;
            DMA_ERR_EXC <= 1'b0;
        end else begin
            PERIPH_INIT <= wif.standby_init;
            NMI_EXC     <= mode_ff == pdm_pkg::PDM_WAKE_OSC
                        && nxt_mode == pdm_pkg::PDM_RUN;
            IRQ_EXC     <= mode_ff == pdm_pkg::PDM_SLEEP
                        && nxt_mode == pdm_pkg::PDM_RUN && irq_accept;
            DMA_ERR_EXC <= mode_ff == pdm_pkg::PDM_SLEEP && nxt_mode == pdm_pkg::PDM_RUN
                        && !irq_accept && DMA_ADDR_ERR;
        end
    end

    assign AVS_READDATA    = rdata_ff;
    assign AVS_WAITREQUEST = wait_ff;

endmodule : pdm_top

// ---- test/pdm_properties.sv ----
// port assertions for the power-down mode controller
`timescale 1ns/1ns
module pdm_properties #(parameter int IRQ_LEVEL_W = 4) (
    // clock, reset and cpu side
    input wire logic CLK_SYS, RST, SLEEP_EXEC, IRQ_REQ, IRQ_ENABLED, DMA_ADDR_ERR,
    input wire logic [IRQ_LEVEL_W-1:0] IRQ_LEVEL, SR_MASK,
    // pins
    input wire logic HW_STANDBY_N, POWER_ON_RESET_N,
    // power control and exceptions
    input wire logic CPU_HALT, CPU_CLK_EN, PERIPH_CLK_EN, WDT_CLK_EN, OSC_EN, PERIPH_INIT,
    input wire logic PORT_HIZ, RAM_RETAIN, CHIP_RESET, HW_STANDBY, NMI_EXC, IRQ_EXC, DMA_ERR_EXC
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_sleep_req; SLEEP_EXEC && !CPU_HALT && !CHIP_RESET; endsequence
    sequence s_stop; !OSC_EN && !WDT_CLK_EN ##1 !PERIPH_INIT; endsequence
    property p_enter; s_sleep_req |=> CPU_HALT && !CPU_CLK_EN && PERIPH_CLK_EN != PERIPH_INIT; endproperty
    a_enter: assert property (p_enter) else $error("sleep entry wrong");
    property p_init; PERIPH_INIT |-> s_stop; endproperty
    a_init: assert property (p_init) else $error("standby init wrong");
    property p_hold; PORT_HIZ || RAM_RETAIN |-> !PERIPH_CLK_EN && !CHIP_RESET; endproperty
    a_hold: assert property (p_hold) else $error("hold outside standby");
    property p_irq; IRQ_EXC |-> !CPU_HALT && $past(CPU_HALT && PERIPH_CLK_EN && IRQ_REQ
        && IRQ_ENABLED && IRQ_LEVEL > SR_MASK); endproperty
    a_irq: assert property (p_irq) else $error("irq wake wrong");
    property p_dma; DMA_ERR_EXC |-> !CPU_HALT && $past(CPU_HALT && PERIPH_CLK_EN && DMA_ADDR_ERR);
    endproperty
    a_dma: assert property (p_dma) else $error("dma wake wrong");
    property p_nmi; NMI_EXC |-> PERIPH_CLK_EN && $past(WDT_CLK_EN && OSC_EN && !PERIPH_CLK_EN);
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi wake wrong");
    property p_hw; !HW_STANDBY_N [*7] |-> HW_STANDBY && CHIP_RESET && !OSC_EN; endproperty
    a_hw: assert property (p_hw) else $error("hw standby missed");
    property p_por; !POWER_ON_RESET_N [*6] |-> CHIP_RESET; endproperty
    a_por: assert property (p_por) else $error("reset pin ignored");
endmodule : pdm_properties
bind pdm_top pdm_properties #(.IRQ_LEVEL_W(IRQ_LEVEL_W)) pdm_properties_i (.*);

// ---- test/pdm_partner.sv ----
// reset supervisor and wake source driving the device pins
`timescale 1ns/1ns
module pdm_partner #(parameter int SETTLE = 20) (
    // clock
    input wire logic CLK_SYS,
    // device pins
    output logic     HW_STANDBY_N, POWER_ON_RESET_N, NMI_PIN
);
    initial {HW_STANDBY_N, POWER_ON_RESET_N, NMI_PIN} = 3'b111;
    task automatic hw_enter();
        @(posedge CLK_SYS) POWER_ON_RESET_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        HW_STANDBY_N <= 1'b0;
    endtask : hw_enter
    // reset stays low until the oscillator has had time to settle
    task automatic hw_leave();
        @(posedge CLK_SYS) HW_STANDBY_N <= 1'b1;
        repeat (SETTLE) @(posedge CLK_SYS);
        POWER_ON_RESET_N <= 1'b1;
    endtask : hw_leave
    task automatic por(input int n);
        @(posedge CLK_SYS) POWER_ON_RESET_N <= 1'b0;
        repeat (n) @(posedge CLK_SYS);
        POWER_ON_RESET_N <= 1'b1;
    endtask : por
    task automatic nmi(input logic lvl);
        @(posedge CLK_SYS) NMI_PIN <= lvl;
    endtask : nmi
endmodule : pdm_partner

// ---- test/tb.sv ----
// self-checking bench for the power-down mode controller
`timescale 1ns/1ns
module tb;
    logic CLK_SYS = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, SLEEP_EXEC = 0, IRQ_REQ = 0;
    logic IRQ_ENABLED = 1, DMA_ADDR_ERR = 0, AVS_WAITREQUEST, HW_STANDBY_N, POWER_ON_RESET_N;
    logic NMI_PIN, CPU_HALT, CPU_CLK_EN, PERIPH_CLK_EN, WDT_CLK_EN, OSC_EN, PERIPH_INIT;
    logic PORT_HIZ, RAM_RETAIN, CHIP_RESET, HW_STANDBY, NMI_EXC, IRQ_EXC, DMA_ERR_EXC;
    logic [4:0]  AVS_ADDRESS = 5'h00;
    logic [3:0]  AVS_BYTEENABLE = 4'hf, IRQ_LEVEL = 4'h0, SR_MASK = 4'h3;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
    logic [7:0]  q;
    int          mismatches = 0, total_checks = 0, n;
    // offset beside the value read after reset; 0x1c is unmapped
    typedef struct {logic [4:0] a; logic [7:0] v;} pdm_row_s;
    pdm_row_s rows[8] = '{'{5'h00, 8'h1f}, '{5'h04, 8'h01}, '{5'h08, 8'h00}, '{5'h0c, 8'h18},
                          '{5'h10, 8'h00}, '{5'h14, 8'h00}, '{5'h18, 8'h00}, '{5'h1c, 8'h00}};
    pdm_top pdm_top_i (.*);
    pdm_partner pdm_partner_i (.*);
    always #5 CLK_SYS = ~CLK_SYS;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge CLK_SYS);
        {AVS_ADDRESS, AVS_WRITE, AVS_READ, AVS_WRITEDATA} <= {a, w, !w, 24'h0, d};
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
        q = AVS_READDATA[7:0];
        {AVS_WRITE, AVS_READ} <= 2'b00;
        if (k >= 20) begin mismatches++; finish_test(); end
    endtask : bus
    task automatic sleep();
        @(posedge CLK_SYS) SLEEP_EXEC <= 1'b1;
        @(posedge CLK_SYS) SLEEP_EXEC <= 1'b0;
        #1;
    endtask : sleep
    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST <= 1'b0;
        foreach (rows[i]) begin bus(1'b0, rows[i].a, 8'h00); chk(q, rows[i].v); end
        $display("reset table done");
        sleep();
        chk({CPU_HALT, PERIPH_CLK_EN}, 2'b11);
        @(posedge CLK_SYS) {IRQ_REQ, IRQ_LEVEL} <= 5'h13;
        repeat (4) @(posedge CLK_SYS);
        chk(CPU_HALT, 1'b1);
        {IRQ_ENABLED, IRQ_LEVEL} <= 5'h04;
        repeat (4) @(posedge CLK_SYS);
        chk(CPU_HALT, 1'b1);
        IRQ_ENABLED <= 1'b1;
        @(posedge CLK_SYS) #1 chk({IRQ_EXC, CPU_HALT}, 2'b10);
        @(posedge CLK_SYS) IRQ_REQ <= 1'b0;
        sleep();
        @(posedge CLK_SYS) DMA_ADDR_ERR <= 1'b1;
        @(posedge CLK_SYS) #1 chk({DMA_ERR_EXC, CPU_HALT}, 2'b10);
        @(posedge CLK_SYS) DMA_ADDR_ERR <= 1'b0;
        $display("sleep done");
        bus(1'b1, 5'h0c, 8'h21);
        bus(1'b1, 5'h00, 8'hc0);
        bus(1'b0, 5'h00, 8'h00);
        chk(q, 8'h1f);
        bus(1'b1, 5'h0c, 8'h01);
        bus(1'b1, 5'h00, 8'hc0);
        bus(1'b1, 5'h04, 8'h00);
        bus(1'b0, 5'h00, 8'h00);
        chk(q, 8'hdf);
        sleep();
        chk({PERIPH_INIT, PORT_HIZ, RAM_RETAIN, OSC_EN, PERIPH_CLK_EN}, 5'b11100);
        pdm_partner_i.nmi(1'b0);
        n = 0;
        while (NMI_EXC !== 1'b1 && n < 4000) begin @(posedge CLK_SYS) #1 n++; end
        chk({NMI_EXC, CPU_HALT}, 2'b10);
        if (n >= 4000) finish_test();
        bus(1'b0, 5'h0c, 8'h00);
        chk(q, 8'h19);
        pdm_partner_i.nmi(1'b1);
        $display("standby done");
        // first pass ends software standby, second pass ends sleep
        for (int k = 0; k < 2; k++) begin
            sleep();
            pdm_partner_i.por(8);
            #1 chk(CHIP_RESET, 1'b1);
            repeat (10) @(posedge CLK_SYS);
            chk(CPU_HALT, 1'b0);
            bus(1'b0, 5'h00, 8'h00);
            chk(q, 8'h1f);
        end
        $display("power-on reset done");
        pdm_partner_i.hw_enter();
        #1 chk(HW_STANDBY, 1'b1);
        repeat (8) @(posedge CLK_SYS);
        #1 chk({HW_STANDBY, CHIP_RESET, OSC_EN}, 3'b110);
        pdm_partner_i.hw_leave();
        repeat (12) @(posedge CLK_SYS);
        #1 chk({HW_STANDBY, CHIP_RESET, CPU_HALT}, 3'b000);
        $display("hw standby done");
        finish_test();
    end
endmodule : tb
